// ==== core/vowl_top.v ====
// Output-voltage protection: fault action byte, warning limits, restart control.
// Assumes a transaction engine on core_clk_in issues command-coded word strobes,
// and that sense, fault comparator and enable arrive unsynchronised from pins.
`timescale 1ns/1ps
`default_nettype none
`include "vowl_defs.vh"

module vowl_top (
	// Clock and reset
	input wire core_clk_in,
	input wire rst_in,
	// Command port from the transaction engine
	input wire [7:0] cmd_code_in,
	input wire wr_strobe_in,
	input wire rd_strobe_in,
	input wire [15:0] wr_data_in,
	output reg [15:0] rd_data_out,
	output reg rd_valid_out,
	input wire clear_faults_in,
	// Converter settings owned elsewhere
	input wire [15:0] output_voltage_target_in,
	input wire voltage_format_select_in,
	input wire [15:0] soft_start_rise_time_in,
	input wire [15:0] startup_timeout_limit_in,
	// Pins from the power stage
	input wire [15:0] vout_sense_in,
	input wire ov_fault_cmp_in,
	input wire other_shutdown_fault_in,
	input wire output_enable_in,
	// Power stage control
	output reg power_stage_on_out,
	// Status and notification
	output reg status_byte_ovf_out,
	output wire status_word_vout_out,
	output reg [7:0] status_vout_out,
	output reg cml_invalid_data_out,
	output wire alert_out
);
	localparam ST_OFF = 6'h01;
	localparam ST_RISE = 6'h02;
	localparam ST_CHECK = 6'h04;
	localparam ST_ON = 6'h08;
	localparam ST_RESTART_WAIT_PERIOD = 6'h10;
	localparam ST_LATCH = 6'h20;
	localparam integer UNIT_CYC_I = `VOWL_UNIT_CYCLES;
	localparam [7:0] UNIT_CYC = UNIT_CYC_I[7:0];

	// Configuration registers
	reg [7:0] ov_fault_action_cfg_r;
	reg [15:0] ov_warning_threshold_r;
	reg [15:0] uv_warning_threshold_r;
	reg [7:0] ov_pct_r;
	reg [7:0] uv_pct_r;

	// Synchronised pins; the sense word is a slow ADC code, so a torn
	// sample at most shifts one comparison by one cycle
	wire [15:0] sense_s;
	wire ov_fault_s;
	wire other_fault_s;
	wire enable_s;

	vowl_sync #(
		.WIDTH(19)
	) u_sync (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.async_in({vout_sense_in, ov_fault_cmp_in, other_shutdown_fault_in, output_enable_in}),
		.sync_out({sense_s, ov_fault_s, other_fault_s, enable_s})
	);

	// Limit mapping against the target present at write time
	wire [15:0] ref_target = voltage_format_select_in ? `VOWL_REL_FULL_SCALE
		: output_voltage_target_in;
	wire [7:0] ov_pct_map;
	wire [7:0] uv_pct_map;
	wire ov_map_ok;
	wire uv_map_ok;

	vowl_pct_map #(
		.LO(`VOWL_OV_PCT_LO),
		.HI(`VOWL_OV_PCT_HI),
		.ROUND_UP(1)
	) u_ov_map (
		.value_in(wr_data_in),
		.target_in(ref_target),
		.pct_out(ov_pct_map),
		.valid_out(ov_map_ok)
	);

	vowl_pct_map #(
		.LO(`VOWL_UV_PCT_LO),
		.HI(`VOWL_UV_PCT_HI),
		.ROUND_UP(0)
	) u_uv_map (
		.value_in(wr_data_in),
		.target_in(ref_target),
		.pct_out(uv_pct_map),
		.valid_out(uv_map_ok)
	);

	// Register writes and invalid-data detection
	wire wr_act = wr_strobe_in && (cmd_code_in == `VOWL_CMD_OV_FAULT_ACTION);
	wire wr_ovw = wr_strobe_in && (cmd_code_in == `VOWL_CMD_OV_WARN_LIMIT);
	wire wr_uvw = wr_strobe_in && (cmd_code_in == `VOWL_CMD_UV_WARN_LIMIT);
	wire act_ok = wr_data_in[`VOWL_ACT_MSB:`VOWL_ACT_LSB] != `VOWL_ACT_INVALID;
	wire bad_write = (wr_act && !act_ok) || (wr_ovw && !ov_map_ok)
		|| (wr_uvw && !uv_map_ok);

	always @(posedge core_clk_in) begin
		if (rst_in) begin
			ov_fault_action_cfg_r <= `VOWL_OV_ACTION_RST;
			ov_warning_threshold_r <= `VOWL_OV_WARN_RST;
			uv_warning_threshold_r <= `VOWL_UV_WARN_RST;
			ov_pct_r <= `VOWL_OV_PCT_RST;
			uv_pct_r <= `VOWL_UV_PCT_RST;
		end else begin
			if (wr_act && act_ok) begin
				ov_fault_action_cfg_r <= wr_data_in[7:0];
			end
			// Stored word is never touched by target changes
			if (wr_ovw && ov_map_ok) begin
				ov_warning_threshold_r <= wr_data_in;
				ov_pct_r <= ov_pct_map;
			end
			if (wr_uvw && uv_map_ok) begin
				uv_warning_threshold_r <= wr_data_in;
				uv_pct_r <= uv_pct_map;
			end
		end
	end

	// Register reads, answered one cycle after the strobe
	always @(posedge core_clk_in) begin
		if (rst_in) begin
			rd_data_out <= 16'h0000;
			rd_valid_out <= 1'b0;
		end else begin
			rd_valid_out <= rd_strobe_in;
			if (rd_strobe_in) begin
				case (cmd_code_in)
					`VOWL_CMD_OV_FAULT_ACTION: rd_data_out <= {8'h00, ov_fault_action_cfg_r};
					`VOWL_CMD_OV_WARN_LIMIT: rd_data_out <= ov_warning_threshold_r;
					`VOWL_CMD_UV_WARN_LIMIT: rd_data_out <= uv_warning_threshold_r;
					default: rd_data_out <= 16'h0000;
				endcase
			end
		end
	end

	// Warning comparators, scaled by the present target
	wire [31:0] sense100 = {16'h0000, sense_s} * 32'd100;
	wire [31:0] ov_thr = {16'h0000, output_voltage_target_in} * {24'h000000, ov_pct_r};
	wire [31:0] uv_thr = {16'h0000, output_voltage_target_in} * {24'h000000, uv_pct_r};
	// The sense chain shows zero for two edges after reset; without this
	// gate that zero would raise a false undervoltage warning
	reg [1:0] settle_r;
	wire ov_warn = settle_r[1] && (sense100 > ov_thr);
	wire uv_warn = settle_r[1] && (sense100 < uv_thr);

	// Restart control
	wire [1:0] act = ov_fault_action_cfg_r[`VOWL_ACT_MSB:`VOWL_ACT_LSB];
	wire [2:0] retry = ov_fault_action_cfg_r[`VOWL_RETRY_MSB:`VOWL_RETRY_LSB];
	wire [2:0] scale = ov_fault_action_cfg_r[`VOWL_SCALE_MSB:`VOWL_SCALE_LSB];
	wire ov_shutdown = ov_fault_s && (act != `VOWL_ACT_IGNORE);
	wire shutdown_fault = ov_shutdown || other_fault_s;
	wire [2:0] restart_wait_period_mult = (scale == 3'h0) ? 3'h1 : scale;
	wire [31:0] rise_u = {16'h0000, soft_start_rise_time_in};
	wire [31:0] tmo_u = {16'h0000, startup_timeout_limit_in};
	// Check window opens at rise end, or at the timeout when one is set
	wire [31:0] win_start = (tmo_u != 32'h0) ? tmo_u : rise_u;
	wire [31:0] win_end = win_start + rise_u;
	wire [31:0] restart_wait_period_u = rise_u * {29'h0, restart_wait_period_mult};

	reg [5:0] state_r;
	reg [5:0] state_nxt;
	reg [7:0] pre_r;
	reg [31:0] elapsed_r;
	reg [2:0] attempts_r;
	reg [2:0] attempts_nxt;
	wire tick = (pre_r == UNIT_CYC - 8'h01);

	always @* begin
		state_nxt = state_r;
		attempts_nxt = attempts_r;
		case (state_r)
			ST_OFF: begin
				// Ignore mode cannot mask a fault that is already there
				if (enable_s && !(ov_fault_s && act == `VOWL_ACT_IGNORE)) begin
					state_nxt = ST_RISE;
				end
			end
			ST_RISE: begin
				if (tick && elapsed_r + 32'h1 >= win_start) begin
					state_nxt = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (tick && elapsed_r + 32'h1 >= win_end) begin
					state_nxt = ST_ON;
					attempts_nxt = 3'h0;
				end
			end
			ST_ON: state_nxt = ST_ON;
			ST_RESTART_WAIT_PERIOD: begin
				if (tick && elapsed_r + 32'h1 >= restart_wait_period_u) begin
					state_nxt = ST_RISE;
				end
			end
			ST_LATCH: state_nxt = ST_LATCH;
			default: state_nxt = ST_OFF;
		endcase
		if (shutdown_fault && (state_r == ST_RISE || state_r == ST_CHECK
			|| state_r == ST_ON)) begin
			if (retry == `VOWL_RETRY_LATCH) begin
				state_nxt = ST_LATCH;
			end else if (retry == `VOWL_RETRY_FOREVER) begin
				state_nxt = ST_RESTART_WAIT_PERIOD;
			end else if (attempts_r >= retry) begin
				state_nxt = ST_LATCH;
			end else begin
				state_nxt = ST_RESTART_WAIT_PERIOD;
				attempts_nxt = attempts_r + 3'h1;
			end
		end
		// Commanding off ends any retry or latch
		if (!enable_s) begin
			state_nxt = ST_OFF;
			attempts_nxt = 3'h0;
		end
	end

	always @(posedge core_clk_in) begin
		if (rst_in) begin
			state_r <= ST_OFF;
			attempts_r <= 3'h0;
			pre_r <= 8'h00;
			elapsed_r <= 32'h0;
			power_stage_on_out <= 1'b0;
		end else begin
			state_r <= state_nxt;
			attempts_r <= attempts_nxt;
			// Times restart from zero on every state change except RISE to CHECK, where elapsed_r loads win_start
			if (state_nxt != state_r) begin
				pre_r <= 8'h00;
				elapsed_r <= 32'h0;
			end else if (tick) begin
				pre_r <= 8'h00;
				elapsed_r <= elapsed_r + 32'h1;
			end else begin
				pre_r <= pre_r + 8'h01;
			end
			// CHECK keeps counting from rise start so one clock reaches win_end
			if (state_r == ST_RISE && state_nxt == ST_CHECK) begin
				elapsed_r <= win_start;
			end
			power_stage_on_out <= (state_nxt == ST_RISE) || (state_nxt == ST_CHECK)
				|| (state_nxt == ST_ON);
		end
	end

	// Sticky status; a new event in the clearing cycle wins
	always @(posedge core_clk_in) begin
		if (rst_in) begin
			status_byte_ovf_out <= 1'b0;
			status_vout_out <= 8'h00;
			settle_r <= 2'h0;
			cml_invalid_data_out <= 1'b0;
		end else begin
			status_byte_ovf_out <= (status_byte_ovf_out && !clear_faults_in)
				|| ov_fault_s;
			status_vout_out[`VOWL_SV_OVF] <= (status_vout_out[`VOWL_SV_OVF]
				&& !clear_faults_in) || ov_fault_s;
			status_vout_out[`VOWL_SV_OVW] <= (status_vout_out[`VOWL_SV_OVW]
				&& !clear_faults_in) || ov_warn;
			status_vout_out[`VOWL_SV_UVW] <= (status_vout_out[`VOWL_SV_UVW]
				&& !clear_faults_in) || uv_warn;
			status_vout_out[4:0] <= 5'h00;
			settle_r <= {settle_r[0], 1'b1};
			cml_invalid_data_out <= (cml_invalid_data_out && !clear_faults_in)
				|| bad_write;
		end
	end

	// Summary bit and host notification
	assign status_word_vout_out = |status_vout_out;
	assign alert_out = status_word_vout_out || status_byte_ovf_out
		|| cml_invalid_data_out;
endmodule
`default_nettype wire

// ==== core/vowl_defs.vh ====
// Constants for the output-voltage protection register block.
// Assumes a 100 MHz core clock and a serial transaction engine outside.
`ifndef VOWL_DEFS_VH
`define VOWL_DEFS_VH

// Command codes
`define VOWL_CMD_OV_FAULT_ACTION 8'h41
`define VOWL_CMD_OV_WARN_LIMIT 8'h42
`define VOWL_CMD_UV_WARN_LIMIT 8'h43

// Fields of the fault action byte
`define VOWL_ACT_MSB 7
`define VOWL_ACT_LSB 6
`define VOWL_RETRY_MSB 5
`define VOWL_RETRY_LSB 3
`define VOWL_SCALE_MSB 2
`define VOWL_SCALE_LSB 0
`define VOWL_ACT_IGNORE 2'h0
`define VOWL_ACT_INVALID 2'h3
`define VOWL_RETRY_LATCH 3'h0
`define VOWL_RETRY_FOREVER 3'h7

// Reset values (stand-ins for the non-volatile copy)
`define VOWL_OV_ACTION_RST 8'h80
`define VOWL_OV_WARN_RST 16'h0233
`define VOWL_UV_WARN_RST 16'h01cd
`define VOWL_OV_PCT_RST 8'h6e
`define VOWL_UV_PCT_RST 8'h5a

// Hardware percentage windows
`define VOWL_OV_PCT_LO 103
`define VOWL_OV_PCT_HI 116
`define VOWL_UV_PCT_LO 84
`define VOWL_UV_PCT_HI 97

// Relative format: 512 counts equal the full target
`define VOWL_REL_FULL_SCALE 16'h0200

// Output status bit positions
`define VOWL_SV_OVF 7
`define VOWL_SV_OVW 6
`define VOWL_SV_UVW 5

// Timing: rise time and startup timeout come in microseconds
`define VOWL_CLK_PERIOD_NS 10
`define VOWL_TIME_UNIT_NS 1000
`define VOWL_UNIT_CYCLES (`VOWL_TIME_UNIT_NS / `VOWL_CLK_PERIOD_NS)

`endif

// ==== core/vowl_sync.v ====
// Two flip-flop synchroniser for a group of independent levels.
// Assumes each bit may change at any time relative to core_clk_in.
`timescale 1ns/1ps
`default_nettype none
module vowl_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input wire core_clk_in,
	input wire rst_in,
	// Levels
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_r;

	always @(posedge core_clk_in) begin
		if (rst_in) begin
			meta_r <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ==== core/vowl_pct_map.v ====
// Maps a warning limit word onto a whole-percent hardware threshold.
// Assumes target is nonzero; a zero target always reports invalid.
`timescale 1ns/1ps
`default_nettype none
module vowl_pct_map #(
	parameter LO = 103,
	parameter HI = 116,
	parameter ROUND_UP = 1
) (
	// Limit and reference
	input wire [15:0] value_in,
	input wire [15:0] target_in,
	// Result
	output reg [7:0] pct_out,
	output wire valid_out
);
	localparam N = HI - LO + 1;
	wire [31:0] v100 = {16'h0000, value_in} * 32'd100;
	wire [31:0] lo_t = {16'h0000, target_in} * LO;
	wire [31:0] hi_t = {16'h0000, target_in} * HI;
	wire [N-1:0] hit;
	integer i;

	genvar k;
	generate
		for (k = 0; k < N; k = k + 1) begin : g_step
			wire [31:0] step_t = {16'h0000, target_in} * (LO + k);
			assign hit[k] = ROUND_UP ? (v100 <= step_t) : (v100 >= step_t);
		end
	endgenerate

	assign valid_out = (target_in != 16'h0000) && (v100 >= lo_t) && (v100 <= hi_t);

	// Pick the nearest step in the rounding direction
	always @* begin
		pct_out = LO[7:0];
		if (ROUND_UP) begin
			for (i = N - 1; i >= 0; i = i - 1) begin
				if (hit[i]) begin
					pct_out = LO[7:0] + i[7:0];
				end
			end
		end else begin
			for (i = 0; i < N; i = i + 1) begin
				if (hit[i]) begin
					pct_out = LO[7:0] + i[7:0];
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== dv/vowl_props.sv ====
// Checker for the output-voltage protection block, bound to its top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module vowl_props (
	// Clock, reset and command port
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic wr_strobe_in,
	input wire logic rd_strobe_in,
	input wire logic [15:0] wr_data_in,
	input wire logic rd_valid_out,
	input wire logic clear_faults_in,
	// Pins and status
	input wire logic ov_fault_cmp_in,
	input wire logic output_enable_in,
	input wire logic power_stage_on_out,
	input wire logic status_byte_ovf_out,
	input wire logic status_word_vout_out,
	input wire logic [7:0] status_vout_out,
	input wire logic cml_invalid_data_out,
	input wire logic alert_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	rd_answer_a: assert property (rd_strobe_in |=> rd_valid_out)
		else $error("read answer missing");
	rd_pulse_a: assert property (rd_valid_out && !rd_strobe_in |=> !rd_valid_out)
		else $error("read valid too long");
	bad_action_a: assert property (wr_strobe_in && cmd_code_in == 8'h41 &&
		wr_data_in[7:6] == 2'h3 |=> ##[0:1] cml_invalid_data_out)
		else $error("action 11b not refused");
	inval_cause_a: assert property ($rose(cml_invalid_data_out) |->
		$past(wr_strobe_in) || $past(wr_strobe_in, 2))
		else $error("invalid flag without write");
	fault_status_a: assert property (ov_fault_cmp_in [*3] |=> status_byte_ovf_out &&
		status_vout_out[7] && status_word_vout_out)
		else $error("fault status late");
	fault_sticky_a: assert property (status_byte_ovf_out && !clear_faults_in |=>
		status_byte_ovf_out)
		else $error("fault bit dropped");
	alert_any_a: assert property (alert_out == (status_vout_out != 8'h00 ||
		status_byte_ovf_out || cml_invalid_data_out))
		else $error("alert mismatch");
	off_disable_a: assert property (!output_enable_in [*5] |-> !power_stage_on_out)
		else $error("power on while disabled");
	on_cause_a: assert property ($rose(power_stage_on_out) |-> $past(output_enable_in, 3))
		else $error("power on without enable");
endmodule
`default_nettype wire

// ==== dv/vowl_host_model.sv ====
// Host-side model: word reads and writes on the command port.
// Assumes tasks are called at a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module vowl_host_model (
	// Clock
	input wire logic core_clk_in,
	// Command port
	output logic [7:0] cmd_code_in,
	output logic wr_strobe_in,
	output logic rd_strobe_in,
	output logic [15:0] wr_data_in,
	input wire logic [15:0] rd_data_out,
	input wire logic rd_valid_out
);
	// Action 11b goes out only when the bench asks for a refusal
	// Fault threshold lies outside; the bench drives the comparator pin
	initial begin
		cmd_code_in = 8'h00;
		wr_strobe_in = 1'b0;
		rd_strobe_in = 1'b0;
		wr_data_in = 16'h0000;
	end
	// Idle lines are inverted so stale values cannot pass for live ones
	task automatic wr_word(input logic [7:0] c, input logic [15:0] d);
		@(negedge core_clk_in);
		cmd_code_in = c;
		wr_data_in = d;
		wr_strobe_in = 1'b1;
		@(negedge core_clk_in);
		wr_strobe_in = 1'b0;
		cmd_code_in = ~c;
		wr_data_in = ~d;
	endtask
	task automatic rd_word(input logic [7:0] c, output logic [15:0] d);
		int n;
		@(negedge core_clk_in);
		cmd_code_in = c;
		rd_strobe_in = 1'b1;
		@(negedge core_clk_in);
		rd_strobe_in = 1'b0;
		cmd_code_in = ~c;
		n = 0;
		while (rd_valid_out !== 1'b1 && n < 4) begin
			@(negedge core_clk_in);
			n++;
		end
		d = (rd_valid_out === 1'b1) ? rd_data_out : 16'hxxxx;
	endtask
endmodule
`default_nettype wire

// ==== dv/test_vowl_top.sv ====
// Testbench for the output-voltage protection block.
// Assumes the host model owns the command port; the bench drives the pins.
`timescale 1ns/1ps
`default_nettype none
`include "vowl_defs.vh"
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
	$display("Error %s expected %h seen %h", n, e, a); end end
module test_vowl_top;
	logic core_clk_in = 0, rst_in = 1, clear_faults_in = 0, voltage_format_select_in = 0;
	logic [15:0] output_voltage_target_in = 16'h0200, soft_start_rise_time_in = 16'h0002;
	logic [15:0] startup_timeout_limit_in = 16'h0000, vout_sense_in = 16'h0200;
	logic ov_fault_cmp_in = 0, other_shutdown_fault_in = 0, output_enable_in = 0;
	wire [7:0] cmd_code_in, status_vout_out;
	wire [15:0] wr_data_in, rd_data_out;
	wire wr_strobe_in, rd_strobe_in, rd_valid_out, power_stage_on_out, status_byte_ovf_out;
	wire status_word_vout_out, cml_invalid_data_out, alert_out;
	int mismatches = 0, checks_done = 0, cycles = 0, n;
	logic [15:0] rv;
	// Command, data, refused, read-back; limits sit at the window edges
	logic [40:0] rows [10] = '{{8'h41, 16'h00c0, 1'b1, 16'h0080},
		{8'h41, 16'h0013, 1'b0, 16'h0013}, {8'h41, 16'hff58, 1'b0, 16'h0058},
		{8'h42, 16'h020f, 1'b1, 16'h0233}, {8'h42, 16'h0210, 1'b0, 16'h0210},
		{8'h42, 16'h0251, 1'b0, 16'h0251}, {8'h42, 16'h0252, 1'b1, 16'h0251},
		{8'h43, 16'h01ae, 1'b1, 16'h01cd}, {8'h43, 16'h01f0, 1'b0, 16'h01f0},
		{8'h43, 16'h01f1, 1'b1, 16'h01f0}};
	vowl_top uut (.*);
	vowl_host_model host (.*);
	initial forever #5 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			close_out;
		end
	end
	task close_out;
		$display("Checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task cyc(input int k);
		repeat (k) @(negedge core_clk_in);
	endtask
	task meas(input logic v);
		n = 0;
		while (power_stage_on_out !== v && n < 3000) begin
			@(negedge core_clk_in);
			n++;
		end
	endtask
	task fault;
		ov_fault_cmp_in = 1;
		meas(0);
		ov_fault_cmp_in = 0;
	endtask
	task clr;
		clear_faults_in = 1;
		cyc(1);
		clear_faults_in = 0;
		cyc(3);
	endtask
	task warn(input logic [15:0] v, input int b, input logic e);
		vout_sense_in = v;
		cyc(5);
		`CHK("warn", e, status_vout_out[b])
	endtask
	initial begin
		cyc(10);
		rst_in = 0;
		host.rd_word(8'h41, rv);
		`CHK("act_rst", {8'h00, `VOWL_OV_ACTION_RST}, rv)
		host.rd_word(8'h42, rv);
		`CHK("ovw_rst", `VOWL_OV_WARN_RST, rv)
		host.rd_word(8'h43, rv);
		`CHK("uvw_rst", `VOWL_UV_WARN_RST, rv)
		host.rd_word(8'h44, rv);
		`CHK("unmapped", 16'h0000, rv)
		`CHK("stat_rst", 8'h00, status_vout_out)
		`CHK("alert_rst", 1'b0, alert_out)
		foreach (rows[i]) begin
			host.wr_word(rows[i][40:33], rows[i][32:17]);
			cyc(2);
			`CHK("invalid", rows[i][16], cml_invalid_data_out)
			`CHK("alert", rows[i][16], alert_out)
			host.rd_word(rows[i][40:33], rv);
			`CHK("readback", rows[i][15:0], rv)
			clr;
		end
		// Limits now 116% and 96% of a 512 target
		warn(16'h0251, 6, 0);
		warn(16'h0252, 6, 1);
		`CHK("word", 1'b1, status_word_vout_out)
		warn(16'h0200, 6, 1);
		clr;
		`CHK("cleared", 8'h00, status_vout_out)
		`CHK("alert_off", 1'b0, alert_out)
		warn(16'h01ec, 5, 0);
		warn(16'h01eb, 5, 1);
		output_voltage_target_in = 16'h0400;
		vout_sense_in = 16'h044c;
		cyc(5);
		clr;
		host.rd_word(8'h42, rv);
		`CHK("kept", 16'h0251, rv)
		warn(16'h04a3, 6, 0);
		warn(16'h04a4, 6, 1);
		// Relative format: limits scale from 512 counts whatever the target
		voltage_format_select_in = 1;
		host.wr_word(8'h42, 16'h0420);
		cyc(2);
		`CHK("rel_bad", 1'b1, cml_invalid_data_out)
		host.wr_word(8'h42, 16'h0210);
		vout_sense_in = 16'h0400;
		cyc(5);
		clr;
		warn(16'h0428, 6, 0);
		warn(16'h0429, 6, 1);
		voltage_format_select_in = 0;
		output_voltage_target_in = 16'h0200;
		vout_sense_in = 16'h0200;
		cyc(5);
		clr;
		// Shutdown, no restart
		host.wr_word(8'h41, 16'h0080);
		output_enable_in = 1;
		meas(1);
		`CHK("on_delay", 1'b1, n >= 2 && n <= 4)
		fault;
		`CHK("off_delay", 1'b1, n <= 5)
		`CHK("ovf", 1'b1, status_byte_ovf_out && status_vout_out[7])
		cyc(1000);
		`CHK("stay_off", 1'b0, power_stage_on_out)
		output_enable_in = 0;
		cyc(5);
		clr;
		// One retry; a good start clears the attempt count
		host.wr_word(8'h41, 16'h0088);
		output_enable_in = 1;
		meas(1);
		fault;
		meas(1);
		`CHK("restart_wait_period", 1'b1, n >= 200 && n <= 206)
		cyc(450);
		fault;
		meas(1);
		`CHK("restart", 1'b1, power_stage_on_out)
		fault;
		cyc(600);
		`CHK("latched", 1'b0, power_stage_on_out)
		output_enable_in = 0;
		cyc(5);
		// Endless retry, restart_wait_period of two rise times
		host.wr_word(8'h41, 16'h00ba);
		output_enable_in = 1;
		meas(1);
		for (int k = 0; k < 3; k++) begin
			fault;
			meas(1);
			`CHK("hiccup2", 1'b1, n >= 400 && n <= 406)
		end
		output_enable_in = 0;
		meas(0);
		`CHK("disable", 1'b1, n <= 6)
		clr;
		// A set timeout moves the success window later
		startup_timeout_limit_in = 16'h0004;
		host.wr_word(8'h41, 16'h0088);
		output_enable_in = 1;
		meas(1);
		fault;
		meas(1);
		cyc(450);
		fault;
		cyc(300);
		`CHK("tmo_latch", 1'b0, power_stage_on_out)
		output_enable_in = 0;
		startup_timeout_limit_in = 16'h0000;
		cyc(5);
		clr;
		// Ignore action: blocked start, then ride through
		host.wr_word(8'h41, 16'h0000);
		ov_fault_cmp_in = 1;
		cyc(4);
		output_enable_in = 1;
		cyc(20);
		`CHK("blocked", 1'b0, power_stage_on_out)
		ov_fault_cmp_in = 0;
		output_enable_in = 0;
		cyc(5);
		output_enable_in = 1;
		meas(1);
		ov_fault_cmp_in = 1;
		cyc(20);
		`CHK("ride", 1'b1, power_stage_on_out && status_byte_ovf_out)
		other_shutdown_fault_in = 1;
		cyc(5);
		`CHK("other", 1'b0, power_stage_on_out)
		close_out;
	end
endmodule
bind vowl_top vowl_props chk (.*);
`default_nettype wire
